// ---- lpm_pkg.sv ----
// Purpose: Shared constants for the low power mode controller.
// Assumes: 8-bit special-function registers written by the core as whole bytes.
// Notes: Bit positions follow the register layouts that firmware programs.
package lpm_pkg;
    localparam int LPM_MON_DIS_BIT = 5;
    localparam int LPM_CLOCK_MODE_REG_B1 = 1;
    localparam int LPM_CLOCK_MODE_REG_B2 = 2;
    localparam int LPM_IDLE_SEL_BIT = 0;
    localparam int LPM_BYPASS_BIT = 6;
    localparam int LPM_N_PCLK = 4;
    localparam int LPM_ACT_LO = 4;
    localparam int LPM_IDLE_LO = 0;
    localparam int LPM_N_WAKE = 4;
    localparam int LPM_CFG_RSTWK_BIT = 4;
    localparam logic [7:0] LPM_CLOCK_MODE_REG_OFF = 8'h00;
    localparam logic [7:0] LPM_RESET_BYTE = 8'h00;
    localparam int LPM_CLK_MHZ = 100;
    localparam int LPM_RST_GUARD_US = 15;
    localparam int LPM_RST_GUARD_CYC = LPM_RST_GUARD_US * LPM_CLK_MHZ;
    typedef enum logic [1:0] {LPM_RUN, LPM_SLEEP, LPM_IDLE} lpm_state_t;
endpackage

// ---- lpm_clk_gate.sv ----
// Purpose: Glitch-free clock gate for one peripheral branch.
// Assumes: Enable is synchronous to CLK.
// Notes: Latch-free style; enable is retimed on the falling edge.
`timescale 1ns/1ps
module lpm_clk_gate (
    input wire logic CLK,
    input wire logic en,
    output logic gclk
);
    logic en_neg_r;

    // The enable changes only while CLK is low, so no pulse is cut short.
    always_ff @(negedge CLK) begin
        en_neg_r <= en;
    end

    assign gclk = CLK & en_neg_r;
endmodule

// ---- lpm_ctrl.sv ----
// Purpose: Power mode and peripheral clock gating controller.
// Assumes: Register write strobes come from the core, one cycle each.
// Notes: No register bus; registers are byte ports with write strobes.
// Operation
// - Sleep retains all state; execution resumes on wake.
// - Four wake sources: oscillator fail, alarm, port match, address match.
// - Writing one to monitor-disable turns supply monitor off.
// - With monitor off, any reset is full power-on and re-enables monitor.
// - Any reset-pin falling edge wakes the device from sleep.
// - Config register shows whether last wake from sleep came from reset pin.
// - Clock-mode bits 1 and 2 enter low power active mode immediately.
// - In active mode gated peripherals stop and their registers are inaccessible.
// - Enable bits 4 to 7 pick running clocks in active mode.
// - Clock-mode written zero or any reset ends active mode.
// - Idle halts core; enable bits 0 to 3 pick running clocks.
// - Idle entered by setting idle-select bit 0 after clock-mode bits.
// - Idle keeps all state; modules may request clocks anytime.
`timescale 1ns/1ps
module lpm_ctrl
    import lpm_pkg::*;
#(
    parameter int N_PCLK = LPM_N_PCLK,
    parameter int GUARD_CYC = LPM_RST_GUARD_CYC
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic ANY_RST,
    input wire logic [7:0] WDATA,
    input wire logic PMU_MD_WR,
    input wire logic CLOCK_MODE_REG_WR,
    input wire logic PERIPH_CLOCK_ENABLE_REG_WR,
    input wire logic POWER_CONTROL_REG_WR,
    input wire logic FLASH_SCALE_REG_WR,
    input wire logic SLEEP_REQ,
    input wire logic [LPM_N_WAKE-1:0] WAKE_EN,
    input wire logic [LPM_N_WAKE-1:0] WAKE_EVT,
    input wire logic RST_PIN_N,
    input wire logic [N_PCLK-1:0] PCLK_REQ,
    output logic [7:0] POWER_MGMT_CONFIG_REG,
    output logic [7:0] CLOCK_MODE_REG,
    output logic [7:0] PERIPH_CLOCK_ENABLE_REG,
    output logic [7:0] FLASH_SCALE_REG,
    output logic SUPPLY_MONITOR_ON,
    output logic FULL_POR,
    output logic LP_ACTIVE,
    output logic CPU_HALT,
    output logic SLEEPING,
    output logic RST_GUARD,
    output logic [N_PCLK-1:0] PCLK_EN,
    output logic [N_PCLK-1:0] PERIPH_CLK
);
    // ---------------------------------------------------------------
    // Mode state
    // ---------------------------------------------------------------
    lpm_state_t state_r, state_nxt;
    logic [7:0] clock_mode_reg_r, clock_mode_reg_nxt;
    logic [7:0] periph_clock_enable_reg_r, periph_clock_enable_reg_nxt;
    logic [7:0] flash_scale_reg_r, flash_scale_reg_nxt;
    logic mon_dis_r, mon_dis_nxt;
    logic rst_wake_r, rst_wake_nxt;
    logic pin_r, pin_nxt;
    logic [$clog2(GUARD_CYC+1)-1:0] guard_r, guard_nxt;
    logic lp_sel, pin_fall, wake_src, rst_all;

    function automatic logic lp_bits(input logic [7:0] v);
        lp_bits = v[LPM_CLOCK_MODE_REG_B1] & v[LPM_CLOCK_MODE_REG_B2];
    endfunction

    assign lp_sel = lp_bits(clock_mode_reg_r);
    assign pin_fall = pin_r & ~RST_PIN_N;
    assign wake_src = |(WAKE_EN & WAKE_EVT);
    // Any chip reset clears mode state; it also clears the monitor disable.
    assign rst_all = SYS_RST | ANY_RST;

    always_comb begin
        state_nxt = state_r;
        clock_mode_reg_nxt = clock_mode_reg_r;
        periph_clock_enable_reg_nxt = periph_clock_enable_reg_r;
        flash_scale_reg_nxt = flash_scale_reg_r;
        mon_dis_nxt = mon_dis_r;
        rst_wake_nxt = rst_wake_r;
        pin_nxt = RST_PIN_N;
        guard_nxt = (guard_r != '0) ? guard_r - 1'b1 : guard_r;
        if (CLOCK_MODE_REG_WR) begin
            clock_mode_reg_nxt = WDATA;
        end
        if (PERIPH_CLOCK_ENABLE_REG_WR) begin
            periph_clock_enable_reg_nxt = WDATA;
        end
        if (FLASH_SCALE_REG_WR) begin
            flash_scale_reg_nxt = WDATA;
        end
        if (PMU_MD_WR && WDATA[LPM_MON_DIS_BIT]) begin
            mon_dis_nxt = 1'b1;
        end
        case (state_r)
            LPM_RUN: begin
                if (POWER_CONTROL_REG_WR && WDATA[LPM_IDLE_SEL_BIT] && lp_bits(clock_mode_reg_nxt)) begin
                    state_nxt = LPM_IDLE;
                end else if (SLEEP_REQ) begin
                    state_nxt = LPM_SLEEP;
                end
            end
            LPM_SLEEP: begin
                if (pin_fall) begin
                    state_nxt = LPM_RUN;
                    rst_wake_nxt = 1'b1;
                    guard_nxt = $bits(guard_r)'(GUARD_CYC);
                end else if (wake_src) begin
                    state_nxt = LPM_RUN;
                    rst_wake_nxt = 1'b0;
                end
            end
            LPM_IDLE: begin
                if (pin_fall || wake_src) begin
                    state_nxt = LPM_RUN;
                end
            end
            default: state_nxt = LPM_RUN;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (rst_all) begin
            state_r <= LPM_RUN;
            clock_mode_reg_r <= LPM_CLOCK_MODE_REG_OFF;
            periph_clock_enable_reg_r <= LPM_RESET_BYTE;
            flash_scale_reg_r <= LPM_RESET_BYTE;
            mon_dis_r <= 1'b0;
            rst_wake_r <= 1'b0;
            pin_r <= 1'b1;
            guard_r <= '0;
        end else begin
            state_r <= state_nxt;
            clock_mode_reg_r <= clock_mode_reg_nxt;
            periph_clock_enable_reg_r <= periph_clock_enable_reg_nxt;
            flash_scale_reg_r <= flash_scale_reg_nxt;
            mon_dis_r <= mon_dis_nxt;
            rst_wake_r <= rst_wake_nxt;
            pin_r <= pin_nxt;
            guard_r <= guard_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Clock gating
    // ---------------------------------------------------------------
    // Outside low power modes every branch runs; requests may reopen a
    // gated branch at any time so wake-capable modules keep working.
    genvar g;
    generate
        for (g = 0; g < N_PCLK; g++) begin : g_br
            logic en;
            always_comb begin
                if (state_r == LPM_IDLE) begin
                    en = periph_clock_enable_reg_r[LPM_IDLE_LO + g] | PCLK_REQ[g];
                end else if (lp_sel) begin
                    en = periph_clock_enable_reg_r[LPM_ACT_LO + g] | PCLK_REQ[g];
                end else begin
                    en = 1'b1;
                end
            end
            assign PCLK_EN[g] = en;
            lpm_clk_gate u_gate (
                .CLK(CLK),
                .en(en),
                .gclk(PERIPH_CLK[g])
            );
        end
    endgenerate

    assign POWER_MGMT_CONFIG_REG = 8'(rst_wake_r) << LPM_CFG_RSTWK_BIT;
    assign CLOCK_MODE_REG = clock_mode_reg_r;
    assign PERIPH_CLOCK_ENABLE_REG = periph_clock_enable_reg_r;
    assign FLASH_SCALE_REG = flash_scale_reg_r;
    assign SUPPLY_MONITOR_ON = ~mon_dis_r;
    assign FULL_POR = ANY_RST & mon_dis_r;
    assign LP_ACTIVE = lp_sel && state_r == LPM_RUN;
    assign CPU_HALT = state_r != LPM_RUN;
    assign SLEEPING = state_r == LPM_SLEEP;
    assign RST_GUARD = guard_r != '0;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (rst_all);

    pin_wake_a: assert property (SLEEPING && pin_fall |=> !SLEEPING && rst_wake_r)
        else $error("reset pin edge did not wake");
    // Without a wake or a register write the sleep state and its settings must survive every cycle.
    sleep_hold_a: assert property (SLEEPING && !pin_fall && !wake_src && !CLOCK_MODE_REG_WR
        && !PERIPH_CLOCK_ENABLE_REG_WR |=> SLEEPING && $stable(clock_mode_reg_r) && $stable(periph_clock_enable_reg_r))
        else $error("sleep state lost");
    idle_hold_a: assert property (state_r == LPM_IDLE && !pin_fall && !wake_src
        |=> CPU_HALT)
        else $error("idle left without wake");
    src_wake_a: assert property (SLEEPING && !pin_fall && wake_src |=> !CPU_HALT)
        else $error("enabled wake source ignored");
    mon_off_a: assert property (PMU_MD_WR && WDATA[LPM_MON_DIS_BIT] |=> !SUPPLY_MONITOR_ON)
        else $error("monitor not disabled");
    lp_exit_a: assert property (CLOCK_MODE_REG_WR && WDATA == LPM_CLOCK_MODE_REG_OFF |=> !LP_ACTIVE)
        else $error("active mode not left");
    idle_enter_a: assert property (state_r == LPM_RUN && POWER_CONTROL_REG_WR && WDATA[LPM_IDLE_SEL_BIT]
        && lp_bits(clock_mode_reg_nxt) |=> CPU_HALT && !SLEEPING)
        else $error("idle not entered");
    idle_gate_a: assert property (state_r == LPM_IDLE |-> PCLK_EN ==
        (periph_clock_enable_reg_r[LPM_IDLE_LO +: N_PCLK] | PCLK_REQ))
        else $error("idle gating wrong");
    act_gate_a: assert property (LP_ACTIVE |-> PCLK_EN ==
        (periph_clock_enable_reg_r[LPM_ACT_LO +: N_PCLK] | PCLK_REQ))
        else $error("active gating wrong");
    guard_a: assert property ($rose(RST_GUARD) |-> RST_GUARD [*8])
        else $error("guard too short");
    cfg_a: assert property (SLEEPING && !pin_fall && wake_src |=>
        !POWER_MGMT_CONFIG_REG[LPM_CFG_RSTWK_BIT])
        else $error("wake cause wrong");

    sleep_c: cover property (SLEEPING ##1 !SLEEPING);
    idle_c: cover property (state_r == LPM_IDLE);
    lpact_c: cover property (LP_ACTIVE ##1 !LP_ACTIVE);
    pinwake_c: cover property (SLEEPING && pin_fall ##1 RST_GUARD);
endmodule

// ---- tb.sv ----
// Purpose: Self-checking bench for the low power mode controller.
// Assumes: Strobes last one cycle; the guard count is shortened to 20 cycles.
// Notes: Every input is driven by non-blocking assignment at a rising edge.
`timescale 1ns/1ps
module tb;
    import lpm_pkg::*;
    localparam int GC = 20;
    logic CLK = 1'b0, SYS_RST = 1'b1, ANY_RST = 1'b0, RST_PIN_N = 1'b1, SLEEP_REQ = 1'b0;
    logic PMU_MD_WR = 1'b0, CLOCK_MODE_REG_WR = 1'b0, PERIPH_CLOCK_ENABLE_REG_WR = 1'b0, POWER_CONTROL_REG_WR = 1'b0, FLASH_SCALE_REG_WR = 1'b0;
    logic [7:0] WDATA = 8'h00;
    logic [3:0] WAKE_EN = 4'hf, WAKE_EVT = 4'h0, PCLK_REQ = 4'h0;
    logic [7:0] cfg, cmr, pcr, fsr;
    logic mon_on, full_por, lp_act, halt, sleeping, guard;
    logic [3:0] pclk_en, pclk;
    int num_errors = 0, cmp_count = 0, n;
    lpm_ctrl #(.N_PCLK(4), .GUARD_CYC(GC)) dut (.CLK(CLK), .SYS_RST(SYS_RST),
        .ANY_RST(ANY_RST), .WDATA(WDATA), .PMU_MD_WR(PMU_MD_WR), .CLOCK_MODE_REG_WR(CLOCK_MODE_REG_WR),
        .PERIPH_CLOCK_ENABLE_REG_WR(PERIPH_CLOCK_ENABLE_REG_WR), .POWER_CONTROL_REG_WR(POWER_CONTROL_REG_WR), .FLASH_SCALE_REG_WR(FLASH_SCALE_REG_WR), .SLEEP_REQ(SLEEP_REQ),
        .WAKE_EN(WAKE_EN), .WAKE_EVT(WAKE_EVT), .RST_PIN_N(RST_PIN_N), .PCLK_REQ(PCLK_REQ),
        .POWER_MGMT_CONFIG_REG(cfg), .CLOCK_MODE_REG(cmr), .PERIPH_CLOCK_ENABLE_REG(pcr),
        .FLASH_SCALE_REG(fsr), .SUPPLY_MONITOR_ON(mon_on), .FULL_POR(full_por),
        .LP_ACTIVE(lp_act), .CPU_HALT(halt), .SLEEPING(sleeping), .RST_GUARD(guard),
        .PCLK_EN(pclk_en), .PERIPH_CLK(pclk));
    always #5 CLK = ~CLK;
    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Selector: 0 power mode, 1 clock mode, 2 clock enable, 3 power control, 4 flash scale.
    task automatic wr(input int k, input logic [7:0] d);
        @(posedge CLK);
        WDATA <= d;
        case (k)
            0: PMU_MD_WR <= 1'b1;
            1: CLOCK_MODE_REG_WR <= 1'b1;
            2: PERIPH_CLOCK_ENABLE_REG_WR <= 1'b1;
            3: POWER_CONTROL_REG_WR <= 1'b1;
            default: FLASH_SCALE_REG_WR <= 1'b1;
        endcase
        @(posedge CLK);
        {PMU_MD_WR, CLOCK_MODE_REG_WR, PERIPH_CLOCK_ENABLE_REG_WR, POWER_CONTROL_REG_WR, FLASH_SCALE_REG_WR} <= 5'h00;
        #1;
    endtask
    // Holds SLEEP_REQ high for a single cycle and returns just after the taking edge.
    task automatic pulse_sleep();
        @(posedge CLK);
        SLEEP_REQ <= 1'b1;
        @(posedge CLK);
        SLEEP_REQ <= 1'b0;
        #1;
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge CLK);
        SYS_RST <= 1'b0;
        @(posedge CLK);
        #1;
        chk("monitor_on", 8'h01, 8'(mon_on));
        chk("pclk_en_reset", 8'h0f, 8'(pclk_en));
        wr(0, 8'h20);
        chk("monitor_off", 8'h00, 8'(mon_on));
        @(posedge CLK);
        ANY_RST <= 1'b1;
        #1;
        chk("full_por", 8'h01, 8'(full_por));
        @(posedge CLK);
        ANY_RST <= 1'b0;
        #1;
        chk("monitor_back", 8'h01, 8'(mon_on));
        wr(1, 8'h06);
        chk("lp_active", 8'h01, 8'(lp_act));
        wr(2, 8'h95);
        chk("active_gate", 8'h09, 8'(pclk_en));
        chk("uart_branches", 8'h01, 8'(pclk_en[0] & pclk_en[3]));
        chk("active_halt", 8'h00, 8'(halt));
        chk("clken_rd", 8'h95, pcr);
        chk("clock_mode_reg_rd", 8'h06, cmr);
        // Firmware keeps the one-shot bypass clear before it asks for idle.
        wr(4, 8'h00);
        chk("bypass_clear", 8'h00, 8'(fsr[LPM_BYPASS_BIT]));
        wr(3, 8'h01);
        chk("idle_halt", 8'h01, 8'(halt));
        chk("idle_gate", 8'h05, 8'(pclk_en));
        chk("idle_keep", 8'h95, pcr);
        @(posedge CLK);
        PCLK_REQ <= 4'h2;
        @(posedge CLK);
        #1;
        chk("clk_request", 8'h07, 8'(pclk_en));
        chk("gated_clk_high", 8'h07, 8'(pclk));
        @(negedge CLK);
        #1;
        chk("gated_clk_low", 8'h00, 8'(pclk));
        @(posedge CLK);
        PCLK_REQ <= 4'h0;
        WAKE_EVT <= 4'h1;
        @(posedge CLK);
        WAKE_EVT <= 4'h0;
        #1;
        chk("idle_wake", 8'h00, 8'(halt));
        wr(1, LPM_CLOCK_MODE_REG_OFF);
        chk("lp_exit", 8'h00, 8'(lp_act));
        chk("all_run", 8'h0f, 8'(pclk_en));
        wr(3, 8'h01);
        chk("idle_refused", 8'h00, 8'(halt));
        wr(4, 8'h40);
        chk("flash_rd", 8'h40, fsr);
        // Pin wake first, so that the later source wakes must clear the cause bit.
        pulse_sleep();
        chk("sleeping_pin", 8'h01, 8'(sleeping));
        @(posedge CLK);
        RST_PIN_N <= 1'b0;
        @(posedge CLK);
        RST_PIN_N <= 1'b1;
        #1;
        chk("pin_wake", 8'h00, 8'(sleeping));
        chk("cfg_pin", 8'h01, 8'(cfg[LPM_CFG_RSTWK_BIT]));
        n = 0;
        while (guard === 1'b1 && n < 100) begin
            n++;
            @(posedge CLK);
            #1;
        end
        chk("guard_len", 8'(GC), 8'(n));
        for (int i = 0; i < 4; i++) begin
            pulse_sleep();
            chk("sleeping", 8'h01, 8'(sleeping));
            @(posedge CLK);
            WAKE_EVT <= 4'(1 << i);
            @(posedge CLK);
            WAKE_EVT <= 4'h0;
            #1;
            chk("src_wake", 8'h00, 8'(sleeping));
            chk("cfg_src", 8'h00, 8'(cfg[LPM_CFG_RSTWK_BIT]));
        end
        pulse_sleep();
        @(posedge CLK);
        WAKE_EN <= 4'h0;
        WAKE_EVT <= 4'h1;
        @(posedge CLK);
        WAKE_EN <= 4'hf;
        WAKE_EVT <= 4'h0;
        #1;
        chk("masked_wake", 8'h01, 8'(sleeping));
        @(posedge CLK);
        WAKE_EVT <= 4'h8;
        @(posedge CLK);
        WAKE_EVT <= 4'h0;
        #1;
        chk("unmasked_wake", 8'h00, 8'(sleeping));
        wr(1, 8'h06);
        @(posedge CLK);
        ANY_RST <= 1'b1;
        #1;
        chk("por_mon_on", 8'h00, 8'(full_por));
        @(posedge CLK);
        ANY_RST <= 1'b0;
        #1;
        chk("rst_lp_exit", 8'h00, 8'(lp_act));
        chk("rst_clock_mode_reg", 8'h00, cmr);
        final_report();
    end
    // The whole sequence needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge CLK);
        num_errors++;
        final_report();
    end
endmodule
